/* File: hw/tmr_defs.svh */
// Register offsets, field positions, reset values and widths of the 16-bit timer block.
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH
`define TMR_OFS_COUNT 8'h00
`define TMR_OFS_CMP_A 8'h04
`define TMR_OFS_CMP_B 8'h08
`define TMR_OFS_MODE 8'h0C
`define TMR_OFS_CLKSEL 8'h10
`define TMR_OFS_OUTCTL 8'h14
`define TMR_OFS_EDGESEL 8'h18
`define TMR_OFS_SAMPSEL 8'h1C
`define TMR_OFS_P3DIR 8'h20
`define TMR_OFS_P3LATCH 8'h24
`define TMR_OFS_CPUCLK 8'h28
`define TMR_OFS_OSCMODE 8'h2C
`define TMR_RST_P3DIR 8'hFF
`define TMR_RST_BYTE 8'h00
`define TMR_RST_WORD 16'h0000
`define TMR_MODE_OVF 0
`define TMR_MODE_LO 1
`define TMR_MODE_HI 3
`define TMR_CLKSEL_LO 4
`define TMR_CLKSEL_HI 6
`define TMR_OUT_ENABLE 0
`define TMR_OUT_LEVEL 1
`define TMR_OUT_PULSE 2
`define TMR_EDGE0_LO 2
`define TMR_EDGE0_HI 3
`define TMR_CPU_EXP_MAX 3'h4
`define TMR_PWM_BASIC_BITS 8
`define TMR_PWM_SUB_BITS 14
`define TMR_SAMP_DIV32 5
`define TMR_SAMP_DIV64 6
`define TMR_SAMP_DIV128 7
`endif

/* File: hw/tmr_pkg.sv */
// Types shared by the 16-bit timer block.
package tmr_pkg;
   typedef enum logic [2:0] {
      TMR_STOP = 3'h0,
      TMR_PWM = 3'h1,
      TMR_FREE = 3'h2,
      TMR_FREE_TI = 3'h3,
      TMR_EDGE_CLR = 3'h4,
      TMR_EDGE_CLR_TI = 3'h5,
      TMR_MATCH_CLR = 3'h6,
      TMR_MATCH_CLR_TI = 3'h7
   } tmr_mode_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
   } tmr_ahb_req_t;
endpackage : tmr_pkg

/* File: hw/tmr_edge_filter.sv */
// Noise filter and valid-edge detector for the external timer input.
`timescale 1ns/1ns
module tmr_edge_filter
   import tmr_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic sample,
   input wire logic pin,
   input wire logic [1:0] edge_sel,
   output logic valid_edge
);
   logic last_sample;
   logic level;

   // A level change is taken only when two consecutive samples agree on it.
   always_ff @(posedge clk) begin
      if (rst) begin
         last_sample <= 1'b0;
         level <= 1'b0;
         valid_edge <= 1'b0;
      end else if (ce) begin
         valid_edge <= 1'b0;
         if (sample) begin
            last_sample <= pin;
            if (pin == last_sample && pin != level) begin
               level <= pin;
               // Select: 00 falling, 01 rising, 11 both, 10 none.
               valid_edge <= pin ? edge_sel[0] : (edge_sel == 2'h0 || edge_sel == 2'h3);
            end
         end
      end
   end
endmodule : tmr_edge_filter

/* File: hw/tmr_top.sv */
// 16-bit timer/event counter with interval, PWM and pulse-generator modes on AHB-Lite.
//
// Summary of operation
// - Reset loads the port 3 direction register with all ones, inputs.
// - Edge-select register is byte written, resets to zero, sets input edges.
// - Sample-clock select is byte written, resets to zero, picks filter clock.
// - Sample choices: CPU clock, main clock over 32, 64, 128; CPU clock halts.
// - CPU clock exponent comes from control bits 0 to 2, legal 0 to 4.
// - In modes 110 and 111 a compare A match clears the counter, counting goes on, interrupt raised.
// - Count clock is chosen by clock-select bits 4 to 6.
// - With the input pin as clock, each valid edge counts once.
// - Code 111 counts watch ticks; other unlisted codes do not count.
// - PWM active width comes from the upper 14 bits of compare A.
// - PWM active level is output-control bit 1.
// - PWM mixes a 256-clock basic cycle with a 16384-clock sub-cycle.
// - Output-control bit 0 enables the timer output onto the pin.
// - Pulse mode gives a square wave: width compare B, period compare A.
// - Mode 000 stops and zeroes, 001 is PWM, 110 clears on compare A.
// - An input edge needs the new level on two consecutive samples.
//
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "tmr_defs.svh"
module tmr_top
   import tmr_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter int PRE_W = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic halt,
   input wire logic watch_tick,
   input wire logic timer_input_pin,
   output logic timer_output_pin,
   output logic timer_output_oe,
   output logic compare_a_irq,
   output logic ext_irq0
);
   if (CNT_W != 16 || PRE_W < 8) begin : g_check
      $error("tmr_top: CNT_W must be 16 and PRE_W at least 8");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers.
   logic [CNT_W-1:0] timer_count;
   logic [CNT_W-1:0] compare_reg_a;
   logic [CNT_W-1:0] compare_reg_b;
   logic [3:0] timer_mode_control;
   logic [2:0] timer_clock_select;
   logic [2:0] timer_output_control;
   logic [7:0] ext_irq_edge_select;
   logic [1:0] sample_clock_select;
   logic [7:0] port3_direction;
   logic [7:0] port3_latch;
   logic [2:0] cpu_clock_control;
   logic main_clock_halve_select;
   tmr_ahb_req_t req;
   tmr_ahb_req_t rd_pend;
   logic [PRE_W-1:0] pre;
   logic out_level;
   logic ti_edge;

   function automatic logic div_tick(input logic [PRE_W-1:0] p, input logic [3:0] e);
      logic [PRE_W-1:0] mask;
      mask = ~({PRE_W{1'b1}} << e);
      div_tick = (p & mask) == mask;
   endfunction : div_tick

   function automatic logic [5:0] rev6(input logic [5:0] v);
      rev6 = {v[0], v[1], v[2], v[3], v[4], v[5]};
   endfunction : rev6

   function automatic logic [31:0] read_mux(input logic [7:0] a);
      case (a)
         `TMR_OFS_COUNT: read_mux = {16'h0000, timer_count};
         `TMR_OFS_CMP_A: read_mux = {16'h0000, compare_reg_a};
         `TMR_OFS_CMP_B: read_mux = {16'h0000, compare_reg_b};
         `TMR_OFS_MODE: read_mux = {28'h0000000, timer_mode_control};
         `TMR_OFS_CLKSEL: read_mux = {25'h0000000, timer_clock_select, 4'h0};
         `TMR_OFS_OUTCTL: read_mux = {29'h00000000, timer_output_control};
         `TMR_OFS_EDGESEL: read_mux = {24'h000000, ext_irq_edge_select};
         `TMR_OFS_SAMPSEL: read_mux = {30'h00000000, sample_clock_select};
         `TMR_OFS_P3DIR: read_mux = {24'h000000, port3_direction};
         `TMR_OFS_P3LATCH: read_mux = {24'h000000, port3_latch};
         `TMR_OFS_CPUCLK: read_mux = {29'h00000000, cpu_clock_control};
         `TMR_OFS_OSCMODE: read_mux = {31'h00000000, main_clock_halve_select};
         default: read_mux = 32'h00000000;
      endcase
   endfunction : read_mux

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: writes take no wait, reads take one so that a write in
   // the preceding data phase is already visible.
   logic addr_ok;
   logic wr_en;
   logic [7:0] wb;
   assign addr_ok = hsel && htrans[1] && hready;
   assign wr_en = ce && req.valid && req.write;
   assign wb = hwdata[7:0];

   always_ff @(posedge clk) begin
      if (rst) begin
         req <= '0;
         rd_pend <= '0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
      end else if (ce) begin
         req <= '0;
         rd_pend <= '0;
         hreadyout <= 1'b1;
         if (addr_ok) begin
            req <= '{valid: 1'b1, write: hwrite, addr: {haddr[7:2], 2'h0}};
            if (!hwrite) begin
               rd_pend <= '{valid: 1'b1, write: 1'b0, addr: {haddr[7:2], 2'h0}};
               hreadyout <= 1'b0;
            end
         end
         if (rd_pend.valid) begin
            hrdata <= read_mux(rd_pend.addr);
         end
      end
   end

   // Byte registers hold the low byte of the written word; compare registers take the low 16 bits.
   always_ff @(posedge clk) begin
      if (rst) begin
         port3_direction <= `TMR_RST_P3DIR;
         port3_latch <= `TMR_RST_BYTE;
         ext_irq_edge_select <= `TMR_RST_BYTE;
         sample_clock_select <= 2'h0;
         timer_clock_select <= 3'h0;
         timer_output_control <= 3'h0;
         cpu_clock_control <= 3'h0;
         main_clock_halve_select <= 1'b0;
         compare_reg_a <= `TMR_RST_WORD;
         compare_reg_b <= `TMR_RST_WORD;
      end else if (wr_en) begin
         case (req.addr)
            `TMR_OFS_P3DIR: port3_direction <= wb;
            `TMR_OFS_P3LATCH: port3_latch <= wb;
            `TMR_OFS_EDGESEL: ext_irq_edge_select <= wb;
            `TMR_OFS_SAMPSEL: sample_clock_select <= wb[1:0];
            `TMR_OFS_CLKSEL: timer_clock_select <= wb[`TMR_CLKSEL_HI:`TMR_CLKSEL_LO];
            `TMR_OFS_OUTCTL: timer_output_control <= wb[2:0];
            `TMR_OFS_CPUCLK: cpu_clock_control <= wb[2:0];
            `TMR_OFS_OSCMODE: main_clock_halve_select <= wb[0];
            `TMR_OFS_CMP_A: compare_reg_a <= hwdata[CNT_W-1:0];
            `TMR_OFS_CMP_B: compare_reg_b <= hwdata[CNT_W-1:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock division. The main clock fxx is clk/2 when halving is off, clk when on.
   logic [3:0] fxx_ofs;
   logic [2:0] cpu_exp;
   logic samp_tick;
   logic cnt_tick;
   tmr_mode_t mode;

   assign fxx_ofs = main_clock_halve_select ? 4'h0 : 4'h1;
   // Exponents above the legal range are held at the largest legal one.
   assign cpu_exp = (cpu_clock_control > `TMR_CPU_EXP_MAX) ? `TMR_CPU_EXP_MAX
                                                           : cpu_clock_control;
   assign mode = tmr_mode_t'(timer_mode_control[`TMR_MODE_HI:`TMR_MODE_LO]);

   always_ff @(posedge clk) begin
      if (rst) begin
         pre <= '0;
      end else if (ce) begin
         pre <= pre + 1'b1;
      end
   end

   // The CPU clock choice is gated by halt, the peripheral choices are not.
   always_comb begin
      case (sample_clock_select)
         2'h0: samp_tick = !halt && div_tick(pre, 4'({1'b0, cpu_exp}) + fxx_ofs);
         2'h1: samp_tick = div_tick(pre, 4'(`TMR_SAMP_DIV32) + fxx_ofs);
         2'h2: samp_tick = div_tick(pre, 4'(`TMR_SAMP_DIV64) + fxx_ofs);
         default: samp_tick = div_tick(pre, 4'(`TMR_SAMP_DIV128) + fxx_ofs);
      endcase
   end

   // Code 001 is 2fxx, only possible when fxx is clk/2, so it is then clk itself.
   always_comb begin
      case (timer_clock_select)
         3'h0: cnt_tick = ti_edge;
         3'h1: cnt_tick = !main_clock_halve_select;
         3'h2: cnt_tick = div_tick(pre, fxx_ofs);
         3'h3: cnt_tick = div_tick(pre, 4'h1 + fxx_ofs);
         3'h4: cnt_tick = div_tick(pre, 4'h2 + fxx_ofs);
         3'h7: cnt_tick = watch_tick;
         default: cnt_tick = 1'b0;
      endcase
   end

   tmr_edge_filter u_filter (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .sample(samp_tick),
      .pin(timer_input_pin),
      .edge_sel(ext_irq_edge_select[`TMR_EDGE0_HI:`TMR_EDGE0_LO]),
      .valid_edge(ti_edge)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Counter, overflow flag and compare interrupt.
   logic match_a;
   logic match_b;
   logic wr_mode;
   logic ovf_set;
   assign match_a = timer_count == compare_reg_a;
   assign match_b = timer_count == compare_reg_b;
   assign wr_mode = wr_en && req.addr == `TMR_OFS_MODE;
   assign ovf_set = cnt_tick && mode != TMR_STOP && mode != TMR_PWM && &timer_count;

   always_ff @(posedge clk) begin
      if (rst) begin
         timer_count <= `TMR_RST_WORD;
         compare_a_irq <= 1'b0;
      end else if (ce) begin
         compare_a_irq <= 1'b0;
         case (mode)
            TMR_STOP: timer_count <= `TMR_RST_WORD;
            TMR_PWM: timer_count <= cnt_tick ? timer_count + 1'b1 : timer_count;
            TMR_FREE, TMR_FREE_TI: begin
               if (cnt_tick) begin
                  timer_count <= timer_count + 1'b1;
                  compare_a_irq <= match_a;
               end
            end
            TMR_EDGE_CLR, TMR_EDGE_CLR_TI: begin
               if (ti_edge) begin
                  timer_count <= `TMR_RST_WORD;
               end else if (cnt_tick) begin
                  timer_count <= timer_count + 1'b1;
                  compare_a_irq <= match_a;
               end
            end
            TMR_MATCH_CLR, TMR_MATCH_CLR_TI: begin
               // Clearing on the tick after the match gives compare+1 ticks.
               if (cnt_tick && match_a) begin
                  timer_count <= `TMR_RST_WORD;
                  compare_a_irq <= 1'b1;
               end else if (cnt_tick) begin
                  timer_count <= timer_count + 1'b1;
               end
            end
            default: timer_count <= `TMR_RST_WORD;
         endcase
      end
   end

   // Overflow is sticky; a hardware set in the clearing write cycle wins.
   always_ff @(posedge clk) begin
      if (rst) begin
         timer_mode_control <= 4'h0;
      end else if (ce) begin
         if (wr_mode) begin
            timer_mode_control <= {wb[`TMR_MODE_HI:`TMR_MODE_LO], wb[`TMR_MODE_OVF] | ovf_set};
         end else if (ovf_set) begin
            timer_mode_control[`TMR_MODE_OVF] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output waveform. PWM: each of 64 basic cycles of 256 clocks is active for
   // the upper eight duty bits, and the low six bits add one clock to that
   // many basic cycles, spread by bit reversal over the sub-cycle so the
   // ripple sits at the basic rate and the filter can be fast.
   logic [13:0] duty;
   logic [8:0] width;
   logic pwm_active;
   logic lvl;
   assign lvl = timer_output_control[`TMR_OUT_LEVEL];
   assign duty = compare_reg_a[CNT_W-1:2];
   assign width = {1'b0, duty[13:6]} +
                  9'(rev6(timer_count[13:8]) < duty[5:0]);
   assign pwm_active = {1'b0, timer_count[`TMR_PWM_BASIC_BITS-1:0]} < width;

   always_ff @(posedge clk) begin
      if (rst) begin
         out_level <= 1'b0;
      end else if (ce) begin
         if (mode == TMR_PWM) begin
            out_level <= pwm_active ? lvl : !lvl;
         end else if (timer_output_control[`TMR_OUT_PULSE] &&
                      (mode == TMR_MATCH_CLR || mode == TMR_MATCH_CLR_TI)) begin
            // Period from compare A, width from compare B.
            if (cnt_tick && match_a) begin
               out_level <= 1'b1;
            end else if (cnt_tick && match_b) begin
               out_level <= 1'b0;
            end
         end
      end
   end

   // The pin shows the timer only while enabled; otherwise the port latch.
   always_ff @(posedge clk) begin
      if (rst) begin
         timer_output_pin <= 1'b0;
         timer_output_oe <= 1'b0;
         ext_irq0 <= 1'b0;
      end else if (ce) begin
         timer_output_pin <= timer_output_control[`TMR_OUT_ENABLE] ? out_level
                                                                   : port3_latch[0];
         timer_output_oe <= !port3_direction[0];
         ext_irq0 <= ti_edge;
      end
   end
endmodule : tmr_top

/* File: tb/tmr_chk_sva.sv */
// Port-level assertions for the 16-bit timer block.
`timescale 1ns/1ns
module tmr_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic timer_output_pin,
   input wire logic timer_output_oe,
   input wire logic compare_a_irq,
   input wire logic ext_irq0
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic take;
   logic wdp;
   assign take = hsel && htrans[1] && hready;
   always_ff @(posedge clk) begin
      wdp <= !rst && take && hwrite;
   end
   sequence s_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   property p_read_wait;
      take && !hwrite |=> s_wait;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read wait wrong");
   property p_write_fast;
      take && hwrite |=> hreadyout;
   endproperty
   a_write_fast: assert property (p_write_fast) else $error("write stalled");
   property p_rdata_hold;
      $changed(hrdata) |-> $past(!hreadyout);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_reset_out;
      $fell(rst) |-> !timer_output_oe && !timer_output_pin;
   endproperty
   a_reset_out: assert property (p_reset_out) else $error("pin not input");
   property p_reset_irq;
      $fell(rst) |-> !compare_a_irq && !ext_irq0;
   endproperty
   a_reset_irq: assert property (p_reset_irq) else $error("irq after reset");
   property p_irq_pulse;
      compare_a_irq |=> !compare_a_irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
   property p_edge_pulse;
      ext_irq0 |=> !ext_irq0;
   endproperty
   a_edge_pulse: assert property (p_edge_pulse) else $error("edge irq long");
   property p_oe_cause;
      $changed(timer_output_oe) |-> $past(wdp) || $past(wdp, 2);
   endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("oe moved alone");
endmodule : tmr_chk
bind tmr_top tmr_chk u_chk (.clk(clk), .rst(rst), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .timer_output_pin(timer_output_pin), .timer_output_oe(timer_output_oe),
   .compare_a_irq(compare_a_irq), .ext_irq0(ext_irq0));

/* File: tb/tmr_ext_src.sv */
// Input signal source and output low-pass filter model.
`timescale 1ns/1ns
module tmr_ext_src (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] half_period,
   input wire logic glitch,
   input wire logic pwm_pin,
   input wire logic pwm_oe,
   output logic src,
   output logic [15:0] lpf_sum,
   output logic lpf_done
);
   logic [7:0] ph;
   logic [13:0] win;
   logic [15:0] acc;
   logic lvl;
   logic cur;
   // A still source keeps its level; a glitch flips the line for one clock.
   always_ff @(posedge clk) begin
      if (rst || half_period == 8'h00) begin
         ph <= 8'h00;
      end else if (ph == half_period - 8'h01) begin
         ph <= 8'h00;
         lvl <= !lvl;
      end else begin
         ph <= ph + 8'h01;
      end
      if (rst) lvl <= 1'b0;
   end
   assign src = lvl ^ glitch;
   assign cur = pwm_oe && pwm_pin;
   // One full sub-cycle summed gives the level an ideal filter settles to.
   always_ff @(posedge clk) begin
      lpf_done <= !rst && win == 14'h3FFF;
      win <= rst ? 14'h0000 : win + 14'h0001;
      acc <= (rst || win == 14'h3FFF) ? 16'h0000 : acc + 16'(cur);
      if (win == 14'h3FFF) lpf_sum <= acc + 16'(cur);
   end
endmodule : tmr_ext_src

/* File: tb/tb_timer16_interval_pwm_ppg.sv */
// Self-checking bench for the 16-bit timer block.
`timescale 1ns/1ns
`include "tmr_defs.svh"
module tb_timer16_interval_pwm_ppg;
   logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic halt = 1'b0, watch_tick = 1'b0, glitch = 1'b0, dp = 1'b0, ce = 1'b1;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
   logic [1:0] htrans = 2'h0, wcnt = 2'h0;
   logic [7:0] hp = 8'h00;
   logic [15:0] lpf_sum, a;
   logic hreadyout, hresp, pin, oe, irq_a, irq0, src, lpf_done;
   logic [31:0] exp_q[$];
   logic [7:0] ck_t[5] = '{8'h10, 8'h20, 8'h30, 8'h40, 8'h70};
   int mul_t[5] = '{1, 2, 4, 8, 3};
   int fail_count = 0, samples_checked = 0, seed = 24157, n, hi, ne, i;
   always #25 clk = ~clk;
   always @(posedge clk) begin
      wcnt <= (wcnt == 2'h2) ? 2'h0 : wcnt + 2'h1;
      watch_tick <= wcnt == 2'h0;
   end
   tmr_top dut (.clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .halt(halt),
      .watch_tick(watch_tick), .timer_input_pin(src), .timer_output_pin(pin),
      .timer_output_oe(oe), .compare_a_irq(irq_a), .ext_irq0(irq0));
   tmr_ext_src u_src (.clk(clk), .rst(rst), .half_period(hp), .glitch(glitch),
      .pwm_pin(pin), .pwm_oe(oe), .src(src), .lpf_sum(lpf_sum), .lpf_done(lpf_done));
   ////////////////////////////////////////////////////////////////
   task chk(input string what, input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, want, seen);
      end
   endtask : chk
   task conclude;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   // Only the watchdog ends a stalled wait.
   task wt;
      do begin
         @(posedge clk);
      end while (hreadyout !== 1'b1);
   endtask : wt
   task wr(input logic [7:0] a8, input logic [31:0] d, input logic w = 1'b1);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a8};
      hwrite <= w;
      wt();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wt();
   endtask : wr
   task rd(input logic [7:0] a8, input logic [31:0] e);
      exp_q.push_back(e);
      wr(a8, 32'h0, 1'b0);
   endtask : rd
   // Read data stands in the cycle that ends with hreadyout high, so it is taken at that edge.
   always @(posedge clk) begin
      if (dp && hreadyout === 1'b1) begin
         chk("read data", hrdata, exp_q.pop_front());
         chk("response", hresp, 32'h0);
         dp <= 1'b0;
      end else if (hsel && htrans[1] && hreadyout === 1'b1 && !hwrite) dp <= 1'b1;
   end
   task cfg(input logic [7:0] ck, input logic [7:0] md, input logic [15:0] av);
      wr(`TMR_OFS_MODE, 32'h0);
      wr(`TMR_OFS_CLKSEL, {24'h0, ck});
      // Interval modes get their compare value before they start, so a stale zero cannot fire.
      if (md != 8'h02) wr(`TMR_OFS_CMP_A, {16'h0, av});
      wr(`TMR_OFS_MODE, {24'h0, md});
      wr(`TMR_OFS_CMP_A, {16'h0, av});
   endtask : cfg
   // The first period after setup may be stale, so the second one is kept.
   task measure;
      repeat (2) begin
         n = 0;
         hi = 0;
         ne = 0;
         for (i = 0; i < 1500 && irq_a !== 1'b1; i++) @(posedge clk);
         do begin
            @(posedge clk);
            n++;
            hi += (pin === 1'b1);
            ne += (irq0 === 1'b1);
         end while (irq_a !== 1'b1 && n < 1500);
      end
   endtask : measure
   ////////////////////////////////////////////////////////////////
   initial begin
      #(100000 * 50);
      fail_count++;
      $display("watchdog expired");
      conclude();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(`TMR_OFS_P3DIR, 32'h000000FF);
      rd(`TMR_OFS_EDGESEL, 32'h0);
      rd(`TMR_OFS_SAMPSEL, 32'h0);
      rd(`TMR_OFS_MODE, 32'h0);
      r = $random(seed);
      wr(`TMR_OFS_EDGESEL, r);
      rd(`TMR_OFS_EDGESEL, r & 32'h000000FF);
      wr(8'h40, r);
      rd(8'h40, 32'h0);
      $display("test registers done");
      for (int c = 0; c < 5; c++) begin
         a = 16'h0010 + 16'($random(seed) & 15);
         cfg(ck_t[c], 8'h0C, a);
         measure();
         chk("interval", n, mul_t[c] * (a + 1));
      end
      cfg(8'h50, 8'h0C, 16'h0010);
      measure();
      chk("no count", n, 1500);
      // Ten frozen clocks stretch one interval of seventeen ticks by ten.
      cfg(8'h10, 8'h0C, 16'h0010);
      for (i = 0; i < 1500 && irq_a !== 1'b1; i++) @(posedge clk);
      ce <= 1'b0;
      repeat (10) @(posedge clk);
      ce <= 1'b1;
      n = 10;
      do begin
         @(posedge clk);
         n++;
      end while (irq_a !== 1'b1 && n < 1500);
      chk("clock enable hold", n, 27);
      wr(`TMR_OFS_MODE, 32'h0);
      rd(`TMR_OFS_COUNT, 32'h0);
      $display("test interval done");
      hp <= 8'h0A;
      for (int e = 0; e < 2; e++) begin
         wr(`TMR_OFS_MODE, 32'h0);
         wr(`TMR_OFS_EDGESEL, e ? 32'h0C : 32'h04);
         cfg(8'h00, 8'h0C, 16'h0003);
         measure();
         chk("edge period", n, e ? 40 : 80);
         chk("edge irq", ne, 4);
      end
      halt <= 1'b1;
      measure();
      chk("halted sample", ne, 0);
      halt <= 1'b0;
      hp <= 8'h00;
      repeat (40) @(posedge clk);
      glitch <= 1'b1;
      @(posedge clk);
      glitch <= 1'b0;
      ne = 0;
      repeat (40) begin
         @(posedge clk);
         ne += (irq0 === 1'b1);
      end
      chk("glitch", ne, 0);
      $display("test input done");
      wr(`TMR_OFS_P3DIR, 32'hFE);
      wr(`TMR_OFS_P3LATCH, 32'h0);
      repeat (2) @(posedge clk);
      chk("oe", oe, 1);
      for (int l = 0; l < 2; l++) begin
         a = 16'($random(seed)) & 16'hFFFC;
         wr(`TMR_OFS_MODE, 32'h0);
         wr(`TMR_OFS_OUTCTL, l ? 32'h01 : 32'h03);
         cfg(8'h10, 8'h02, a);
         // Let the new duty reach the pin before the window that is kept can start.
         repeat (4) @(posedge clk);
         repeat (2) begin
            for (i = 0; i < 20000 && lpf_done !== 1'b1; i++) @(posedge clk);
            @(posedge clk);
         end
         chk("duty", lpf_sum, l ? 16'h4000 - a[15:2] : a[15:2]);
      end
      $display("test pwm done");
      wr(`TMR_OFS_MODE, 32'h0);
      wr(`TMR_OFS_OUTCTL, 32'h05);
      wr(`TMR_OFS_CMP_B, 32'h5);
      cfg(8'h10, 8'h0C, 16'h0014);
      measure();
      chk("pulse period", n, 21);
      chk("pulse width", hi, 6);
      wr(`TMR_OFS_OUTCTL, 32'h0);
      wr(`TMR_OFS_P3LATCH, 32'h1);
      repeat (2) @(posedge clk);
      chk("latch pin", pin, 1);
      $display("test pulse done");
      conclude();
   end
endmodule : tb_timer16_interval_pwm_ppg
